// ### inc/uwp_pkg.sv
// Types shared by the redirected-write block
package uwp_pkg;

    // ------------------------------------------------------------
    // Decoded write frame from the air-interface front end
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  opcode;
        logic [1:0]  membank;
        logic [15:0] word_ptr;
        logic [15:0] data;
        logic [15:0] rn16;
        logic        handle_ok;
        logic        crc_ok;
        logic        state_ok;
    } uwp_cmd_t;

    // ------------------------------------------------------------
    // Reply to the front end
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       success;
        logic [7:0] err_code;
    } uwp_reply_t;

endpackage

// ### inc/uwp_regs.svh
// Offsets, field positions, reset values and reply codes of the redirected-write block
`ifndef UWP_REGS_SVH
`define UWP_REGS_SVH

// ------------------------------------------------------------
// Command frame fields
// ------------------------------------------------------------
`define UWP_OP_WRITE       8'hC3
`define UWP_BANK_USER      2'h3
`define UWP_PTR_REDIRECT   16'hF7FF

// ------------------------------------------------------------
// USER bank map
// ------------------------------------------------------------
`define UWP_ADDR_CTL       10'h002
`define UWP_ADDR_PTR       10'h003
`define UWP_USER_START     10'h006
`define UWP_USER_LAST      10'h3FF
`define UWP_PTR_RESET      10'h006
`define UWP_CTL_RESET      3'h0

// ------------------------------------------------------------
// Control word bits and pointer word field
// ------------------------------------------------------------
`define UWP_CTL_STEP       0
`define UWP_CTL_WRAP       1
`define UWP_CTL_LOCK       2
`define UWP_PTR_MSB        9

// ------------------------------------------------------------
// Error reply codes
// ------------------------------------------------------------
`define UWP_ERR_NONE       8'h00
`define UWP_ERR_OVERRUN    8'h03
`define UWP_ERR_LOCKED     8'h04

`endif

// ### logic/uwp_mem.sv
// USER bank word storage: one write port, one combinational read port
module uwp_mem #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    // Nonvolatile array: no reset, contents survive
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// ### logic/uwp_top.sv
// Redirected single-word writes into the USER bank through the working pointer
// What this block does
// [RL1] A redirected write is a write frame with opcode C3, bank 11 and word pointer F7FF carrying one data word.
// [RL2] It obeys every check of an ordinary write: handle, CRC and tag state, with the same reply behaviour.
// [RL3] Only once a valid redirected write is accepted is the step enable bit looked at.
// [RL4] With step disabled the decoded word goes to the pointer address and the pointer stays put.
// [RL5] With step disabled the interrogator must rewrite the pointer itself or the same word is overwritten.
// [RL6] With step enabled the pointer is advanced by one and the word is written there.
// [RL7] After a stepping write the pointer holds the address just written.
// [RL8] Successive stepping writes land on consecutive addresses, eight of them moving the pointer by eight.
// [RL9] The pointer starts at the first USER word, 006, and only this controller or host writes change it.
// [RL10] The interrogator fetches a fresh random number per write and covers the data word with it.
// [RL11] The pointer is a read/write word at USER 003 whose low ten bits are the address.
// [RL12] An ordinary write to USER 003 loads the pointer directly.
// [RL13] The pointer addresses only the USER bank, never other banks; redirected writes below its data area are refused.
// [RL14] Without wrap, once the pointer sits on the last word further redirected writes are refused.
// [RL15] Pointer step and memory write act together; a refused write leaves the pointer as it was.
// [RL16] A redirected write gets the normal write success or error reply, in ordinary write timing.
`include "uwp_regs.svh"

module uwp_top
    import uwp_pkg::*;
#(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          cmd_valid,
    input  wire uwp_cmd_t      cmd,
    input  wire logic          rd_req,
    input  wire logic [AW-1:0] rd_addr,
    output uwp_reply_t         reply,
    output logic               rd_valid,
    output logic      [DW-1:0] rd_data,
    output logic      [AW-1:0] ptr_out
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Two-byte extensible form packs seven bits per byte
    function automatic logic [AW-1:0] ebv_addr(input logic [15:0] wp);
        logic [13:0] a;
        a = wp[15] ? {wp[14:8], wp[6:0]} : {7'h00, wp[6:0]};
        return a[AW-1:0];
    endfunction

    function automatic logic in_span(input logic [AW-1:0] a, input logic [AW-1:0] top);
        return (a >= `UWP_USER_START) && (a <= top);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [AW-1:0] ptr_q, ptr_d;
    logic [2:0]    ctl_q, ctl_d;
    uwp_reply_t    reply_q, reply_d;
    logic          rd_valid_q;
    logic [DW-1:0] rd_data_q, rd_data_d;
    logic [DW-1:0] mem_rdata;

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    wire is_write    = cmd_valid && (cmd.opcode == `UWP_OP_WRITE) && (cmd.membank == `UWP_BANK_USER);
    wire accepted    = is_write && cmd.crc_ok && cmd.handle_ok && cmd.state_ok; // RL2
    wire is_redirect = accepted && (cmd.word_ptr == `UWP_PTR_REDIRECT); // RL1
    wire is_plain    = accepted && (cmd.word_ptr != `UWP_PTR_REDIRECT);
    wire [DW-1:0] data_word = cmd.data ^ cmd.rn16; // RL10
    wire [AW-1:0] plain_addr = ebv_addr(cmd.word_ptr);

    wire step   = ctl_q[`UWP_CTL_STEP];
    wire wrap   = ctl_q[`UWP_CTL_WRAP];
    wire alock  = ctl_q[`UWP_CTL_LOCK];
    wire at_last = (ptr_q == `UWP_USER_LAST);

    // ------------------------------------------------------------
    // Redirected target and refusal
    // ------------------------------------------------------------
    // Wrap reloads the first data word rather than running into the register words
    wire [AW-1:0] ptr_inc   = at_last ? `UWP_PTR_RESET : AW'(ptr_q + 1'b1);
    wire [AW-1:0] redir_addr = (is_redirect && step) ? ptr_inc : ptr_q; // RL3 RL4 RL6
    wire redir_overrun = at_last && !wrap; // RL14
    wire redir_outside = (redir_addr < `UWP_USER_START); // RL13
    wire redir_locked  = alock && in_span(redir_addr, ptr_q);
    wire redir_ok      = is_redirect && !redir_overrun && !redir_outside && !redir_locked; // RL15

    wire plain_locked  = alock && in_span(plain_addr, ptr_q);
    wire plain_ok      = is_plain && !plain_locked;
    wire wr_ctl        = plain_ok && (plain_addr == `UWP_ADDR_CTL);
    wire wr_ptr        = plain_ok && (plain_addr == `UWP_ADDR_PTR); // RL11 RL12

    wire          mem_we    = redir_ok || (plain_ok && !wr_ctl && !wr_ptr);
    wire [AW-1:0] mem_waddr = redir_ok ? redir_addr : plain_addr; // RL4 RL6

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        ptr_d = ptr_q;
        if (redir_ok && step) begin
            ptr_d = redir_addr; // RL7 RL8
        end else if (wr_ptr) begin
            ptr_d = data_word[`UWP_PTR_MSB:0]; // RL12
        end
    end

    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = data_word[2:0];
            // Wrap and auto-lock exclude each other; wrap wins
            if (data_word[`UWP_CTL_WRAP]) begin
                ctl_d[`UWP_CTL_LOCK] = 1'b0;
            end
        end
    end

    always_comb begin
        reply_d.valid    = accepted; // RL16
        reply_d.success  = redir_ok || plain_ok;
        reply_d.err_code = `UWP_ERR_NONE;
        if (is_redirect && (redir_overrun || redir_outside)) begin
            reply_d.err_code = `UWP_ERR_OVERRUN;
        end else if ((is_redirect && redir_locked) || (is_plain && plain_locked)) begin
            reply_d.err_code = `UWP_ERR_LOCKED;
        end
    end

    assign rd_data_d = (rd_addr == `UWP_ADDR_CTL) ? DW'(ctl_q) :
                       (rd_addr == `UWP_ADDR_PTR) ? DW'(ptr_q) : mem_rdata;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ptr_q      <= `UWP_PTR_RESET; // RL9
            ctl_q      <= `UWP_CTL_RESET;
            reply_q    <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end else begin
            ptr_q      <= ptr_d;
            ctl_q      <= ctl_d;
            reply_q    <= reply_d;
            rd_valid_q <= rd_req;
            rd_data_q  <= rd_data_d;
        end
    end

    uwp_mem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clock (clock),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (data_word),
        .raddr (rd_addr),
        .rdata (mem_rdata)
    );

    assign reply    = reply_q;
    assign rd_valid = rd_valid_q;
    assign rd_data  = rd_data_q;
    assign ptr_out  = ptr_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence step_write_s;
        redir_ok && step && !at_last;
    endsequence

    a_hold_no_step: assert property (@(posedge clock) disable iff (!rst_n) // RL4
        redir_ok && !step |=> ptr_q == $past(ptr_q))
        else $error("pointer moved on a non-stepping redirected write");

    a_step_advance: assert property (@(posedge clock) disable iff (!rst_n) // RL6
        step_write_s |=> ptr_q == AW'($past(ptr_q) + 1'b1))
        else $error("stepping write did not advance pointer by one");

    a_two_steps: assert property (@(posedge clock) disable iff (!rst_n) // RL8
        step_write_s ##1 (step_write_s and !wr_ptr) |=> ptr_q == AW'($past(ptr_q, 2) + 2'd2))
        else $error("consecutive stepping writes not consecutive");

    a_write_target: assert property (@(posedge clock) disable iff (!rst_n) // RL7
        step_write_s |-> mem_we && (mem_waddr == AW'(ptr_q + 1'b1)) ##1 (ptr_q == $past(mem_waddr)))
        else $error("stepping write target differs from new pointer");

    a_refused_keep: assert property (@(posedge clock) disable iff (!rst_n) // RL15
        is_redirect && !redir_ok |-> !mem_we ##1 (ptr_q == $past(ptr_q)))
        else $error("refused redirected write changed state");

    a_overrun_refuse: assert property (@(posedge clock) disable iff (!rst_n) // RL14
        is_redirect && at_last && !wrap |=> reply.valid && !reply.success && reply.err_code == `UWP_ERR_OVERRUN)
        else $error("redirected write past last word not refused");

    a_reply_timing: assert property (@(posedge clock) disable iff (!rst_n) // RL16
        accepted |=> reply.valid)
        else $error("accepted write not answered next cycle");

    a_bad_frame_quiet: assert property (@(posedge clock) disable iff (!rst_n) // RL2
        cmd_valid && !(cmd.crc_ok && cmd.handle_ok && cmd.state_ok) |=> !reply.valid && $stable(ptr_q))
        else $error("bad frame answered or changed pointer");

    a_manual_load: assert property (@(posedge clock) disable iff (!rst_n) // RL12
        wr_ptr && !redir_ok |=> ptr_q == $past(data_word[`UWP_PTR_MSB:0]))
        else $error("write to pointer word not loaded");

    a_user_only: assert property (@(posedge clock) disable iff (!rst_n) // RL13
        redir_ok |-> mem_waddr >= `UWP_USER_START)
        else $error("redirected write outside USER data area");

    a_reset_value: assert property (@(posedge clock) // RL9
        !rst_n |=> ptr_q == `UWP_PTR_RESET)
        else $error("pointer not at start after reset");

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the redirected-write block
`include "uwp_regs.svh"

module tb_top
    import uwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clock = 1'b0;
    logic            rst_n = 1'b0;
    logic            cmd_valid;
    uwp_cmd_t        cmd;
    logic            rd_req = 1'b0;
    logic [9:0]      rd_addr = 10'h000;
    uwp_reply_t      reply;
    logic            rd_valid;
    logic [15:0]     rd_data;
    logic [9:0]      ptr_out;
    uwp_reply_t      rq[$];
    logic [15:0]     dq[$];
    logic [15:0]     d[8];
    int              n_errors = 0;
    int              n_checks = 0;

    always #25 clock = ~clock;

    uwp_rdr_model i_rdr (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd));

    uwp_top i_dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .rd_req(rd_req),
                   .rd_addr(rd_addr), .reply(reply), .rd_valid(rd_valid), .rd_data(rd_data), .ptr_out(ptr_out));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A bad frame pushes nothing: any reply to it meets an empty queue
    task automatic wr(input logic [15:0] ptr, input logic [15:0] word, input logic good, input logic [7:0] err);
        if (good) begin
            rq.push_back({1'b1, err == `UWP_ERR_NONE, err});
        end
        i_rdr.send(ptr, word, good);
    endtask

    task automatic rd(input logic [9:0] addr, input logic [15:0] exp);
        @(negedge clock);
        rd_req  <= 1'b1;
        rd_addr <= addr;
        dq.push_back(exp);
        @(negedge clock);
        rd_req  <= 1'b0;
    endtask

    // Outputs settle after the rising edge, so the watcher looks at the falling one
    always @(negedge clock) begin
        if (reply.valid === 1'b1) begin
            chk((rq.size() != 0) ? {6'h00, rq.pop_front()} : 16'hDEAD, {6'h00, reply});
        end
        if (rd_valid === 1'b1) begin
            chk((dq.size() != 0) ? dq.pop_front() : 16'hDEAD, rd_data);
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h74411fe1));
        repeat (20) @(negedge clock);
        rst_n <= 1'b1;
        rd(`UWP_ADDR_PTR, 16'h0006);
        rd(`UWP_ADDR_CTL, 16'h0000);
        wr(16'h0002, 16'h0001, 1'b1, `UWP_ERR_NONE);
        for (int i = 0; i < 8; i++) begin
            d[i] = 16'($urandom);
            wr(`UWP_PTR_REDIRECT, d[i], 1'b1, `UWP_ERR_NONE);
        end
        i_rdr.idle();
        rd(`UWP_ADDR_PTR, 16'h000E);
        chk(16'h000E, {6'h00, ptr_out});
        for (int i = 0; i < 8; i++) begin
            rd(10'(7 + i), d[i]);
        end
        wr(`UWP_PTR_REDIRECT, 16'h1234, 1'b0, `UWP_ERR_NONE);
        i_rdr.idle();
        rd(`UWP_ADDR_PTR, 16'h000E);
        wr(16'h0002, 16'h0000, 1'b1, `UWP_ERR_NONE);
        wr(16'h0003, 16'h0020, 1'b1, `UWP_ERR_NONE);
        wr(`UWP_PTR_REDIRECT, 16'hA5A5, 1'b1, `UWP_ERR_NONE);
        wr(`UWP_PTR_REDIRECT, 16'h5A5A, 1'b1, `UWP_ERR_NONE);
        i_rdr.idle();
        rd(`UWP_ADDR_PTR, 16'h0020);
        rd(10'h020, 16'h5A5A);
        wr(16'h0003, 16'h03FF, 1'b1, `UWP_ERR_NONE);
        wr(`UWP_PTR_REDIRECT, 16'h0F0F, 1'b1, `UWP_ERR_OVERRUN);
        wr(16'h0003, 16'h0005, 1'b1, `UWP_ERR_NONE);
        wr(`UWP_PTR_REDIRECT, 16'h0F0F, 1'b1, `UWP_ERR_OVERRUN);
        i_rdr.idle();
        rd(`UWP_ADDR_PTR, 16'h0005);
        wr(16'h0002, 16'h0003, 1'b1, `UWP_ERR_NONE);
        wr(16'h0003, 16'h03FF, 1'b1, `UWP_ERR_NONE);
        wr(`UWP_PTR_REDIRECT, 16'h1357, 1'b1, `UWP_ERR_NONE);
        wr(16'h0002, 16'h0005, 1'b1, `UWP_ERR_NONE);
        wr(`UWP_PTR_REDIRECT, 16'h2468, 1'b1, `UWP_ERR_NONE);
        wr(16'h0007, 16'hFFFF, 1'b1, `UWP_ERR_LOCKED);
        i_rdr.idle();
        rd(`UWP_ADDR_PTR, 16'h0007);
        rd(10'h006, 16'h1357);
        rd(10'h007, 16'h2468);
        repeat (4) @(negedge clock);
        if (rq.size() != 0 || dq.size() != 0) begin
            n_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, 16'h0000, 16'(rq.size() + dq.size()));
        end
        report_and_stop();
    end
endmodule

// ### tb/uwp_rdr_model.sv
// Interrogator stand-in: sends decoded write frames to the redirected-write block
`include "uwp_regs.svh"

module uwp_rdr_model
    import uwp_pkg::*;
(
    input  wire logic clock,
    output logic      cmd_valid,
    output uwp_cmd_t  cmd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // ------------------------------------------------------------
    // Frame drivers
    // ------------------------------------------------------------
    // Valid stays high so calls in a row give one frame per cycle
    task automatic send(input logic [15:0] ptr, input logic [15:0] word, input logic good);
        logic [15:0] rn;
        rn = 16'($urandom);
        @(negedge clock);
        cmd_valid      <= 1'b1;
        cmd.opcode     <= `UWP_OP_WRITE;
        cmd.membank    <= `UWP_BANK_USER;
        cmd.word_ptr   <= ptr;
        cmd.rn16       <= rn;
        cmd.data       <= word ^ rn;
        cmd.handle_ok  <= 1'b1;
        cmd.crc_ok     <= good;
        cmd.state_ok   <= 1'b1;
    endtask

    // Released lines carry the inverse so no stale frame looks valid
    task automatic idle();
        @(negedge clock);
        cmd_valid <= 1'b0;
        cmd       <= ~cmd;
    endtask
endmodule
